//--- logic/sbsp_port.v
// Synchronous pipelined burst static memory, 32K words of 32 bits
`timescale 1ns/1ps
`include "sbsp_consts.vh"

module sbsp_port (
	input  wire        i_clk,
	input  wire        i_sys_rst,
	input  wire [14:0] i_addr_in,
	input  wire [31:0] i_data_lines_in,
	output wire [31:0] o_data_lines_out,
	output wire        o_data_lines_oe,
	input  wire        i_out_enable_n,
	input  wire        i_burst_advance_n,
	input  wire        i_ctrl_addr_strobe_n,
	input  wire        i_proc_addr_strobe_n,
	input  wire        i_chip_select_first_n,
	input  wire        i_chip_select_second_n,
	input  wire        i_chip_select_third,
	input  wire [3:0]  i_byte_lane_write_n,
	input  wire        i_byte_write_gate_n,
	input  wire        i_all_bytes_write_n,
	input  wire        i_burst_order_interleave,
	input  wire        i_sleep_request,
	output wire        o_in_ready
);

	// ----------------------------------------------------------------
	// Local constants
	// ----------------------------------------------------------------
	// Pipeline operation codes, one-hot
	localparam [2:0] OP_IDLE = 3'b001;
	localparam [2:0] OP_RD   = 3'b010;
	localparam [2:0] OP_WR   = 3'b100;

	// Sleep qualification time in cycles, rounded up, at least one
	localparam integer SLEEP_CYC_I =
		(`SBSP_SLEEP_SETUP_NS + `SBSP_CLK_PERIOD_NS - 1) / `SBSP_CLK_PERIOD_NS;
	localparam [`SBSP_SLEEP_CYC_W-1:0] SLEEP_CYC =
		(SLEEP_CYC_I < 1) ? 2'h1 : SLEEP_CYC_I[`SBSP_SLEEP_CYC_W-1:0];

	// ----------------------------------------------------------------
	// Burst order function
	// ----------------------------------------------------------------
	// Low address bits for a given start and count
	function [1:0] burst_low;
		input [1:0] start;
		input [1:0] count;
		input       interleave;
		begin
			if (interleave)
				burst_low = start ^ count;
			else
				burst_low = start + count;
		end
	endfunction

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	reg [31:0] mem [0:`SBSP_WORDS-1]; // Memory array
	reg [12:0] burst_hi;              // Fixed upper address bits
	reg [1:0]  burst_start;           // Low bits at burst start
	reg [1:0]  burst_cnt;             // Burst counter
	reg        burst_active;          // Burst open, not deselected
	reg [2:0]  op;                    // Operation in stage two
	reg [14:0] op_addr;               // Address of that operation
	reg [31:0] op_wdata;              // Write data of that operation
	reg [3:0]  op_lane_we;            // Byte lanes to write
	reg [31:0] out_data;              // Read output register
	reg        out_valid;             // Output register holds read data
	reg [1:0]  sleep_cnt;             // Cycles sleep has been held
	reg        sleep_act;             // Sleep recognised

	// ----------------------------------------------------------------
	// Input decode
	// ----------------------------------------------------------------
	// All three enables in their active state
	wire sel = ~i_chip_select_first_n & ~i_chip_select_second_n
		& i_chip_select_third;

	// Any write request, global or gated lanes
	wire wr_req = ~i_all_bytes_write_n
		| (~i_byte_write_gate_n & ~(&i_byte_lane_write_n));

	// Per-lane write enables for this cycle
	wire [3:0] lane_we = {4{~i_all_bytes_write_n}}
		| ({4{~i_byte_write_gate_n}} & ~i_byte_lane_write_n);

	// Burst start from processor strobe, always a read
	wire start_proc = sel & ~i_proc_addr_strobe_n;

	// Burst start from controller strobe
	wire start_ctrl = sel & i_proc_addr_strobe_n
		& ~i_ctrl_addr_strobe_n;

	// Two deselect cases
	wire desel = (i_chip_select_first_n & ~i_ctrl_addr_strobe_n)
		| (~i_chip_select_first_n & ~sel
		& (~i_proc_addr_strobe_n | ~i_ctrl_addr_strobe_n));

	// Strobe pattern for continue or suspend
	wire cont_cond = (i_proc_addr_strobe_n & i_ctrl_addr_strobe_n)
		| (i_chip_select_first_n & i_ctrl_addr_strobe_n);

	// Counter and address for the next step
	wire [1:0] cnt_step = burst_cnt + 2'h1;
	wire [1:0] lo_next  = burst_low(burst_start, cnt_step,
		i_burst_order_interleave);
	wire [1:0] lo_same  = burst_low(burst_start, burst_cnt,
		i_burst_order_interleave);

	// ----------------------------------------------------------------
	// Read data buffer
	// ----------------------------------------------------------------
	wire        fifo_in_ready;  // Room for another read word
	wire        fifo_out_valid; // Read word waiting
	wire [31:0] fifo_out_data;  // Oldest read word

	// Pipeline runs when awake and buffer has room
	wire run = ~sleep_act & fifo_in_ready;
	assign o_in_ready = run;

	// Array read pushed when stage two holds a read
	wire rd_push = run & (op == OP_RD);

	sbsp_fifo #(
		.WIDTH (`SBSP_DATA_W),
		.DEPTH (`SBSP_FIFO_DEPTH),
		.PTR_W (`SBSP_FIFO_PTR_W)
	) u_rd_fifo (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_in_valid  (rd_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (mem[op_addr]),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (~sleep_act),
		.o_out_data  (fifo_out_data)
	);

	// ----------------------------------------------------------------
	// Sleep qualification
	// ----------------------------------------------------------------
	// Sleep is taken once held for the setup time
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			sleep_cnt <= 2'h0;
			sleep_act <= 1'b0;
		end else if (i_sleep_request) begin
			// Count up while held, saturate
			if (sleep_cnt != SLEEP_CYC)
				sleep_cnt <= sleep_cnt + 2'h1;
			if (sleep_cnt + 2'h1 >= SLEEP_CYC)
				sleep_act <= 1'b1;
		end else begin
			// Low level wakes at once
			sleep_cnt <= 2'h0;
			sleep_act <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Input stage
	// ----------------------------------------------------------------
	// Capture address, controls and write data on the edge
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			burst_hi     <= 13'h0;
			burst_start  <= 2'h0;
			burst_cnt    <= 2'h0;
			burst_active <= 1'b0;
			op           <= OP_IDLE;
			op_addr      <= 15'h0;
			op_wdata     <= 32'h0;
			op_lane_we   <= 4'h0;
		end else if (run) begin
			if (start_proc | start_ctrl) begin
				// New burst at the external address
				burst_hi     <= i_addr_in[14:2];
				burst_start  <= i_addr_in[1:0];
				burst_cnt    <= 2'h0;
				burst_active <= 1'b1;
				op_addr      <= i_addr_in;
				op_wdata     <= i_data_lines_in;
				if (start_ctrl & wr_req) begin
					op         <= OP_WR;
					op_lane_we <= lane_we;
				end else begin
					op         <= OP_RD;
					op_lane_we <= 4'h0;
				end
			end else if (desel) begin
				// Deselect, held until the next start
				burst_active <= 1'b0;
				op           <= OP_IDLE;
				op_lane_we   <= 4'h0;
			end else if (cont_cond & burst_active) begin
				// Continue or suspend within the burst
				op_wdata <= i_data_lines_in;
				if (~i_burst_advance_n) begin
					burst_cnt <= cnt_step;
					op_addr   <= {burst_hi, lo_next};
				end else begin
					op_addr   <= {burst_hi, lo_same};
				end
				if (wr_req) begin
					op         <= OP_WR;
					op_lane_we <= lane_we;
				end else begin
					op         <= OP_RD;
					op_lane_we <= 4'h0;
				end
			end else begin
				// Nothing to do this cycle
				op         <= OP_IDLE;
				op_lane_we <= 4'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Array write
	// ----------------------------------------------------------------
	// Merge new bytes into the stored word lane by lane
	wire [31:0] merged;
	genvar g;
	generate
		for (g = 0; g < `SBSP_LANES; g = g + 1) begin : g_lane
			assign merged[g*8 +: 8] = op_lane_we[g]
				? op_wdata[g*8 +: 8]
				: mem[op_addr][g*8 +: 8];
		end
	endgenerate

	// Write the merged word, no reset on the array
	always @(posedge i_clk) begin
		if (!i_sys_rst && run) begin
			case (op)
				OP_WR: begin
					mem[op_addr] <= merged;
				end
				OP_RD: begin
					// Read handled by the buffer push
				end
				OP_IDLE: begin
					// No access
				end
				default: begin
					// Unused codes, no access
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	// Read word lands in the output register
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			out_data  <= 32'h0;
			out_valid <= 1'b0;
		end else if (!sleep_act) begin
			if (fifo_out_valid) begin
				out_data  <= fifo_out_data;
				out_valid <= 1'b1;
			end else begin
				// Nothing to show, bus released
				out_valid <= 1'b0;
			end
		end
	end

	// Drivers follow output enable without a clock
	assign o_data_lines_oe  = out_valid & ~i_out_enable_n
		& ~sleep_act;
	assign o_data_lines_out = out_data;

endmodule // sbsp_port

// Small flip-flop FIFO with valid and ready on both sides
module sbsp_fifo #(
	parameter WIDTH  = 32,
	parameter DEPTH  = 4,
	parameter PTR_W  = 2
) (
	input  wire             i_clk,
	input  wire             i_sys_rst,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	reg [WIDTH-1:0] store [0:DEPTH-1]; // Word slots
	reg [PTR_W-1:0] wr_ptr;            // Next slot to fill
	reg [PTR_W-1:0] rd_ptr;            // Next slot to drain
	reg [PTR_W:0]   fill;              // Words held

	wire push = i_in_valid & o_in_ready;
	wire pop  = o_out_valid & i_out_ready;

	assign o_in_ready  = (fill != DEPTH[PTR_W:0]);
	assign o_out_valid = (fill != {(PTR_W+1){1'b0}});
	assign o_out_data  = store[rd_ptr];

	// Pointer and level upkeep
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			wr_ptr <= {PTR_W{1'b0}};
			rd_ptr <= {PTR_W{1'b0}};
			fill   <= {(PTR_W+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & ~pop)
				fill <= fill + 1'b1;
			else if (pop & ~push)
				fill <= fill - 1'b1;
		end
	end

	// Word write, no reset needed on data
	always @(posedge i_clk) begin
		if (push)
			store[wr_ptr] <= i_in_data;
	end

endmodule // sbsp_fifo

//--- logic/sbsp_consts.vh
// Constants for the synchronous burst static memory port
`ifndef SBSP_CONSTS_VH
`define SBSP_CONSTS_VH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define SBSP_ADDR_W        15
`define SBSP_DATA_W        32
`define SBSP_WORDS         32768
`define SBSP_LANES         4
`define SBSP_LANE_W        8
`define SBSP_HI_W          13
`define SBSP_LO_W          2

// ----------------------------------------------------------------
// Read data buffer
// ----------------------------------------------------------------
`define SBSP_FIFO_DEPTH    4
`define SBSP_FIFO_PTR_W    2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SBSP_CLK_PERIOD_NS 25
`define SBSP_SLEEP_SETUP_NS 8
`define SBSP_SLEEP_HOLD_NS 0
`define SBSP_SLEEP_CYC_W   2

`endif

//--- logic/sbsp_fifo.v
// The read data buffer module is defined in sbsp_port.v, beside the port logic

//--- bench/sbsp_port_assertions.sv
// Concurrent checks on the pins of the burst static memory port
`timescale 1ns/1ps

module sbsp_port_chk (
	input wire       i_clk,
	input wire       i_sys_rst,
	input wire       o_data_lines_oe,
	input wire       i_out_enable_n,
	input wire       i_ctrl_addr_strobe_n,
	input wire       i_proc_addr_strobe_n,
	input wire       i_chip_select_first_n,
	input wire       i_chip_select_second_n,
	input wire       i_chip_select_third,
	input wire [3:0] i_byte_lane_write_n,
	input wire       i_byte_write_gate_n,
	input wire       i_all_bytes_write_n,
	input wire       i_sleep_request,
	input wire       o_in_ready
);
	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	wire wr    = !i_all_bytes_write_n || (!i_byte_write_gate_n && !(&i_byte_lane_write_n)); // Write request
	wire sel   = !i_chip_select_first_n && !i_chip_select_second_n && i_chip_select_third;  // All enables on
	wire rd_go = o_in_ready && sel && (!i_proc_addr_strobe_n || (!i_ctrl_addr_strobe_n && !wr)); // Read start
	wire desel = (i_chip_select_first_n && !i_ctrl_addr_strobe_n)
		|| (!i_chip_select_first_n && !sel && !(i_proc_addr_strobe_n && i_ctrl_addr_strobe_n)); // Deselect
	wire quiet = !i_sleep_request && (!o_in_ready || desel || (wr && i_proc_addr_strobe_n)); // No new read

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	oe_gate_a: assert property (o_data_lines_oe |-> !i_out_enable_n)
		else $error("data lines driven with output enable off");
	rst_quiet_a: assert property ($past(i_sys_rst) |-> !o_data_lines_oe)
		else $error("data lines driven right after reset");
	rst_ready_a: assert property ($past(i_sys_rst) && !i_sleep_request |-> o_in_ready)
		else $error("not ready after reset");
	sleep_ready_a: assert property (i_sleep_request [*3] |-> !o_in_ready)
		else $error("commands taken while asleep");
	sleep_quiet_a: assert property (i_sleep_request [*3] |-> !o_data_lines_oe)
		else $error("data lines driven while asleep");
	awake_ready_a: assert property ((!i_sleep_request) [*8] |-> o_in_ready)
		else $error("not ready while awake");
	// Sleep freezes the pipe, so only reads with the port awake throughout are timed
	read_lat_a: assert property ((rd_go && !i_sleep_request) ##1 (!i_sleep_request) [*2]
		|=> (o_data_lines_oe || i_out_enable_n))
		else $error("read word missing two edges after start");
	idle_quiet_a: assert property (quiet [*4] |=> !o_data_lines_oe)
		else $error("data lines driven with no read pending");
endmodule // sbsp_port_chk

bind sbsp_port sbsp_port_chk chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_data_lines_oe(o_data_lines_oe),
	.i_out_enable_n(i_out_enable_n), .i_ctrl_addr_strobe_n(i_ctrl_addr_strobe_n),
	.i_proc_addr_strobe_n(i_proc_addr_strobe_n), .i_chip_select_first_n(i_chip_select_first_n),
	.i_chip_select_second_n(i_chip_select_second_n), .i_chip_select_third(i_chip_select_third),
	.i_byte_lane_write_n(i_byte_lane_write_n), .i_byte_write_gate_n(i_byte_write_gate_n),
	.i_all_bytes_write_n(i_all_bytes_write_n), .i_sleep_request(i_sleep_request), .o_in_ready(o_in_ready));

//--- bench/sbsp_bus_model.sv
// Controller-side model of the shared data lines
`timescale 1ns/1ps

module sbsp_bus_model (
	input  wire         i_clk,
	input  wire         i_drive,
	input  wire  [31:0] i_wdata,
	input  wire         i_dev_oe,
	input  wire  [31:0] i_dev_data,
	output logic [31:0] o_bus
);
	logic [31:0] last = 32'h0; // Last level seen on the lines

	// Device first, then controller; a floating bus never repeats its level
	always_comb o_bus = i_dev_oe ? i_dev_data : (i_drive ? i_wdata : ~last);

	// Remember the level for the floating case
	always @(posedge i_clk) last <= o_bus;
endmodule // sbsp_bus_model

//--- bench/testbench.sv
// Self-checking bench for the burst static memory port
`timescale 1ns/1ps

module testbench;
	// ------------------------------------------------------------
	// Stimulus, observation and bookkeeping
	// ------------------------------------------------------------
	localparam [5:0]  PRD = 6'h0b, CST = 6'h0d, NXT = 6'h0e, HLD = 6'h0f, DSL = 6'h2d; // Command codes
	localparam [12:0] HI  = 13'h0a5;  // Upper address used by most tests
	logic        i_clk = 0;           // System clock
	logic        i_sys_rst = 1;       // Reset, high
	logic [5:0]  c = DSL;             // Enables, strobes and step
	logic [5:0]  w = 6'h3f;           // Global, gate and lane writes
	logic [14:0] addr = 0;            // Word address
	logic [31:0] wd = 0, bus, dout;   // Write data, lines, read data
	logic        oe, rdy, oe_n = 0, ilv = 0, slp = 0, drv = 0;
	logic [31:0] mem [0:32767];       // Reference array
	logic [31:0] got[$], exp_q[$];    // Seen and expected words
	int          err_total = 0, comparisons = 0, cycles = 0;

	always #12.5 i_clk = ~i_clk;

	sbsp_port dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr_in(addr), .i_data_lines_in(bus),
		.o_data_lines_out(dout), .o_data_lines_oe(oe), .i_out_enable_n(oe_n), .i_burst_advance_n(c[0]),
		.i_ctrl_addr_strobe_n(c[1]), .i_proc_addr_strobe_n(c[2]), .i_chip_select_first_n(c[5]),
		.i_chip_select_second_n(c[4]), .i_chip_select_third(c[3]), .i_byte_lane_write_n(w[3:0]),
		.i_byte_write_gate_n(w[4]), .i_all_bytes_write_n(w[5]), .i_burst_order_interleave(ilv),
		.i_sleep_request(slp), .o_in_ready(rdy));
	sbsp_bus_model bus_m (.i_clk(i_clk), .i_drive(drv), .i_wdata(wd), .i_dev_oe(oe), .i_dev_data(dout), .o_bus(bus));

	// Collect driven words and cut a hang short
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (oe === 1'b1) got.push_back(dout);
		if (cycles == 400) begin
			err_total++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] expv);
		comparisons++;
		if (seen !== expv) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask

	// One bus cycle; the controller drives the lines only when writing
	task cyc(input logic [5:0] cc, input logic [14:0] a, input logic [5:0] ww, input logic [31:0] d);
		@(posedge i_clk);
		c <= cc;
		addr <= a;
		w <= ww;
		wd <= d;
		drv <= !ww[5] || (!ww[4] && !(&ww[3:0]));
	endtask

	// Expected burst address for step k
	function logic [14:0] ba(input logic [14:0] s, input int k, input int m);
		ba = {s[14:2], (m != 0) ? s[1:0] ^ k[1:0] : s[1:0] + k[1:0]};
	endfunction

	// Let the pipe empty, then compare every word
	task drain(input string name);
		repeat (6) cyc(DSL, 0, 6'h3f, 0);
		check(got.size(), exp_q.size());
		foreach (exp_q[i]) if (i < got.size()) check(got[i], exp_q[i]);
		got.delete();
		exp_q.delete();
		$display("test %s done", name);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Write burst then read burst in both orders, with wrap
	task t_burst();
		logic [31:0] v;
		for (int m = 0; m < 2; m++) begin
			@(posedge i_clk);
			ilv <= m[0];
			for (int k = 0; k < 4; k++) begin
				v = 32'h5a5a_0000 + m * 16 + k;
				cyc(k ? NXT : CST, {HI, 2'd2}, 6'h1f, v);
				mem[ba({HI, 2'd2}, k, m)] = v;
			end
			for (int k = 0; k < 5; k++) begin
				cyc(k ? NXT : PRD, {HI, 2'd1}, 6'h3f, 0);
				exp_q.push_back(mem[ba({HI, 2'd1}, k, m)]);
			end
			drain("burst");
		end
	endtask

	// Lane writes, gate off counts as read, processor start ignores writes
	task t_lanes();
		cyc(CST, 15'h7fff, 6'h1f, 32'h0);
		cyc(CST, 15'h7fff, 6'h2a, 32'hffff_ffff);
		cyc(CST, 15'h7fff, 6'h30, 32'hffff_ffff);
		cyc(PRD, 15'h7fff, 6'h1f, 32'h1234_5678);
		cyc(PRD, 15'h7fff, 6'h3f, 0);
		repeat (3) exp_q.push_back(32'h00ff_00ff);
		mem[15'h7fff] = 32'h00ff_00ff;
		drain("lanes");
	endtask

	// Suspend, deselect holds, restart reloads, output enable off
	task automatic t_hold();
		logic [5:0] seq [9] = '{PRD, HLD, HLD, NXT, 6'h03, NXT, NXT, PRD, NXT};
		int         lo [6] = '{0, 0, 0, 1, 3, 0};
		@(posedge i_clk);
		ilv <= 1'b0;
		foreach (seq[i]) cyc(seq[i], {HI, (i == 7) ? 2'd3 : 2'd0}, 6'h3f, 0);
		foreach (lo[i]) exp_q.push_back(mem[{HI, lo[i][1:0]}]);
		repeat (4) cyc(DSL, 0, 6'h3f, 0);
		cyc(PRD, {HI, 2'd0}, 6'h3f, 0);
		oe_n <= 1'b1;
		drain("hold");
		oe_n <= 1'b0;
	endtask

	// A write while asleep is refused and the array is kept
	task t_sleep();
		@(posedge i_clk);
		slp <= 1'b1;
		repeat (3) cyc(DSL, 0, 6'h3f, 0);
		cyc(CST, {HI, 2'd0}, 6'h1f, 32'hdead_beef);
		@(negedge i_clk);
		check(rdy, 1'b0);
		cyc(DSL, 0, 6'h3f, 0);
		slp <= 1'b0;
		cyc(PRD, {HI, 2'd0}, 6'h3f, 0);
		@(negedge i_clk);
		check(rdy, 1'b1);
		exp_q.push_back(mem[{HI, 2'd0}]);
		drain("sleep");
	endtask

	// ------------------------------------------------------------
	// Main sequence and verdict
	// ------------------------------------------------------------
	task final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_burst();
		t_lanes();
		t_hold();
		t_sleep();
		final_report();
	end
endmodule // testbench
